// ===== pkg/scs_regs.vh
// register offsets, field positions, addresses and timing counts of the serial control slave
`ifndef SCS_REGS_VH
`define SCS_REGS_VH
`define SCS_REG_CFG_SRC 8'h00
`define SCS_REG_MODE 8'h01
`define SCS_CFG_SRC_RST 8'h00
`define SCS_MODE_RST 8'h00
`define SCS_CFG_SRC_BIT 0
`define SCS_MODE_LSB 2
`define SCS_SER_ADDR0 7'h69
`define SCS_SER_ADDR1 7'h6A
`define SCS_SER_ADDR2 7'h6B
`define SCS_SER_ADDR3 7'h6E
`define SCS_DES_ADDR0 7'h71
`define SCS_DES_ADDR1 7'h72
`define SCS_DES_ADDR2 7'h73
`define SCS_DES_ADDR3 7'h76
`define SCS_PWRUP_MS 10
`define SCS_CLK_KHZ 25000
`define SCS_PWRUP_CYC (`SCS_PWRUP_MS * `SCS_CLK_KHZ)
`define SCS_FILT_LEN 3
`endif

// ===== hw/scs_ctrl_filter.v
// glitch filter for the three control outputs, one output clock per enable
`timescale 1ns/100ps
`default_nettype none
`include "scs_regs.vh"
module scs_ctrl_filter (
    input wire clk,
    input wire nrst,
    input wire tick,
    input wire enable,
    input wire [2:0] ctrl_in,
    output reg [2:0] ctrl_out
);
    reg [2:0] last_q;
    reg [1:0] cnt_q [0:2];
    integer i;
    // a level must hold for three output clocks before it passes
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            last_q <= 3'h0;
            ctrl_out <= 3'h0;
            for (i = 0; i < 3; i = i + 1) begin
                cnt_q[i] <= 2'h0;
            end
        end else if (tick) begin
            for (i = 0; i < 3; i = i + 1) begin
                if (!enable) begin
                    ctrl_out[i] <= ctrl_in[i];
                    cnt_q[i] <= 2'h0;
                end else if (ctrl_in[i] != last_q[i]) begin
                    cnt_q[i] <= 2'h1;
                end else if (cnt_q[i] != 2'h0 && cnt_q[i] < 2'h3) begin
                    cnt_q[i] <= cnt_q[i] + 2'h1;
                    if (cnt_q[i] == 2'h2)
                        ctrl_out[i] <= ctrl_in[i];
                end
                last_q[i] <= ctrl_in[i];
            end
        end
    end
endmodule // scs_ctrl_filter
`default_nettype wire

// ===== hw/scs_slave.v
// serial control slave: bus engine, configuration registers, mode select
`timescale 1ns/100ps
`default_nettype none
`include "scs_regs.vh"
module scs_slave #(
    parameter IS_DESER = 1,
    parameter PWRUP_CYC = `SCS_PWRUP_CYC
) (
    input wire clk,
    input wire nrst,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe_n,
    input wire [1:0] address_select_pin,
    input wire [1:0] mode_pin,
    input wire recovered_clock_out,
    input wire [2:0] ctrl_in,
    output reg [2:0] ctrl_out,
    output reg [1:0] mode,
    output reg cfg_from_regs,
    output reg ready
);
    localparam ST_IDLE = 6'h01;
    localparam ST_ADDR = 6'h02;
    localparam ST_AACK = 6'h04;
    localparam ST_WR = 6'h08;
    localparam ST_RD = 6'h10;
    localparam ST_RACK = 6'h20;

    // state flow of one transaction:
    // idle waits for a start; addr shifts in the slave address and direction;
    // aack holds the acknowledge low through the ninth clock, then either
    // hands over to wr for register address and data bytes, or loads the
    // first read byte and moves to rd; rd shifts a byte out msb first and
    // rack samples the master's answer in the ninth clock.
    // a stop or a new start is honoured in any state, so a master that
    // aborts mid-byte always finds the slave back at a clean boundary.

    // first and second synchroniser stages of the bus lines and the output clock
    reg [1:0] scl_s_q, sda_s_q, rck_s_q;
    // one more stage behind the synchronisers, used to find edges; sda_q also gives the sampled data bit
    reg scl_q, sda_q, rck_q;
    reg [1:0] id_s1_q, id_s2_q, md_s1_q, md_s2_q;
    reg [2:0] ci_s1_q, ci_s2_q;
    // 28 bits cover the full hold-off at 25 MHz with room to spare
    reg [27:0] pwr_q;
    reg [5:0] st_q;
    reg [3:0] bit_q;
    reg [7:0] sh_q;
    reg rw_q, have_ptr_q, ack_hold_q;
    reg [7:0] ptr_q, cfg_q, mode_q;
    wire scl_rise, scl_fall, start_c, stop_c, tick;
    wire [6:0] own_addr;
    wire [2:0] filt_out;

    // address table per device flavour
    function [6:0] addr_of;
        input des;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: addr_of = des ? `SCS_DES_ADDR0 : `SCS_SER_ADDR0;
                2'h1: addr_of = des ? `SCS_DES_ADDR1 : `SCS_SER_ADDR1;
                2'h2: addr_of = des ? `SCS_DES_ADDR2 : `SCS_SER_ADDR2;
                default: addr_of = des ? `SCS_DES_ADDR3 : `SCS_SER_ADDR3;
            endcase
        end
    endfunction

    // register read mux, unmapped reads return zero
    // a function because the first and every later read byte use it
    function [7:0] rd_of;
        input [7:0] a;
        input [7:0] c;
        input [7:0] m;
        begin
            if (a == `SCS_REG_CFG_SRC)
                rd_of = c;
            else if (a == `SCS_REG_MODE)
                rd_of = m;
            else
                rd_of = 8'h00;
        end
    endfunction

    // two-flop synchronisers for every pin from outside
    // bus lines reset to their idle high level so that release of reset
    // cannot be mistaken for a start, a stop or a clock edge
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            rck_s_q <= 2'h0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            rck_q <= 1'b0;
            id_s1_q <= 2'h3;
            id_s2_q <= 2'h3;
            md_s1_q <= 2'h0;
            md_s2_q <= 2'h0;
            ci_s1_q <= 3'h0;
            ci_s2_q <= 3'h0;
        end else begin
            scl_s_q <= {scl_s_q[0], scl_in};
            sda_s_q <= {sda_s_q[0], sda_in};
            rck_s_q <= {rck_s_q[0], recovered_clock_out};
            scl_q <= scl_s_q[1];
            sda_q <= sda_s_q[1];
            rck_q <= rck_s_q[1];
            id_s1_q <= address_select_pin;
            id_s2_q <= id_s1_q;
            md_s1_q <= mode_pin;
            md_s2_q <= md_s1_q;
            ci_s1_q <= ctrl_in;
            ci_s2_q <= ci_s1_q;
        end
    end

    // edge and condition detection on the synchronised lines
    // an edge is seen two to three clocks after the pin moves; the bus needs
    // its high and low phases to last at least four clocks so that no edge
    // is lost and data is sampled well after it settled
    assign scl_rise = scl_s_q[1] & ~scl_q;
    assign scl_fall = ~scl_s_q[1] & scl_q;
    assign start_c = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
    assign stop_c = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];
    assign tick = rck_s_q[1] & ~rck_q;
    assign own_addr = addr_of(IS_DESER != 0, id_s2_q);

    // power-up hold-off: bus ignored until the count expires
    // the engine is held idle rather than gated at the pins, so a transfer
    // already running when the count expires is ignored until the next start
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pwr_q <= 28'h000_0000;
            ready <= 1'b0;
        end else if (!ready) begin
            pwr_q <= pwr_q + 28'h000_0001;
            if (pwr_q >= PWRUP_CYC - 1)
                ready <= 1'b1;
        end
    end

    // bus engine: byte shifting, ack, register access
    // the register pointer survives a repeated start, which is what lets a
    // read continue from the address set by the preceding write
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= ST_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            rw_q <= 1'b0;
            have_ptr_q <= 1'b0;
            ack_hold_q <= 1'b0;
            ptr_q <= 8'h00;
            cfg_q <= `SCS_CFG_SRC_RST;
            mode_q <= `SCS_MODE_RST;
            sda_oe_n <= 1'b1;
        end else if (!ready || stop_c) begin
            st_q <= ST_IDLE;
            sda_oe_n <= 1'b1;
        end else if (start_c) begin
            st_q <= ST_ADDR;
            bit_q <= 4'h0;
            have_ptr_q <= 1'b0;
            sda_oe_n <= 1'b1;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    // idle only waits; the start test above the case does the work
                    sda_oe_n <= 1'b1;
                end
                ST_ADDR, ST_WR: begin
                    if (scl_rise) begin
                        sh_q <= {sh_q[6:0], sda_q};
                        bit_q <= bit_q + 4'h1;
                    end
                    if (scl_fall && bit_q == 4'h8) begin
                        bit_q <= 4'h0;
                        if (st_q == ST_ADDR) begin
                            rw_q <= sh_q[0];
                            if (sh_q[7:1] == own_addr) begin
                                sda_oe_n <= 1'b0;
                                st_q <= ST_AACK;
                            end else begin
                                st_q <= ST_IDLE;
                            end
                        end else begin
                            // first byte of a write sets the pointer, later ones land at it
                            if (!have_ptr_q) begin
                                ptr_q <= sh_q;
                                have_ptr_q <= 1'b1;
                            end else begin
                                // writes to unmapped registers are acknowledged and dropped
                                if (ptr_q == `SCS_REG_CFG_SRC)
                                    cfg_q <= sh_q;
                                else if (ptr_q == `SCS_REG_MODE)
                                    mode_q <= sh_q;
                                ptr_q <= ptr_q + 8'h01;
                            end
                            sda_oe_n <= 1'b0;
                            st_q <= ST_AACK;
                        end
                    end
                end
                ST_AACK: begin
                    // after the ack clock's falling edge: release for a write, put out bit 7 for a read
                    if (scl_fall) begin
                        if (rw_q) begin
                            sh_q <= rd_of(ptr_q, cfg_q, mode_q);
                            sda_oe_n <= rd_of(ptr_q, cfg_q, mode_q) >> 7 == 8'h01;
                            ptr_q <= ptr_q + 8'h01;
                            bit_q <= 4'h1;
                            rw_q <= 1'b0;
                            st_q <= ST_RD;
                        end else begin
                            sda_oe_n <= 1'b1;
                            st_q <= ST_WR;
                        end
                    end
                end
                ST_RD: begin
                    // bit 7 was already put out when the ack clock fell
                    if (scl_fall) begin
                        if (bit_q == 4'h8) begin
                            sda_oe_n <= 1'b1; // master's ack slot
                            st_q <= ST_RACK;
                        end else begin
                            sda_oe_n <= sh_q[7 - bit_q[2:0]];
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    // master nack ends the read; ack fetches the next byte
                    // the answer is latched at the rising edge, when it is settled
                    if (scl_rise)
                        ack_hold_q <= sda_q;
                    if (scl_fall) begin
                        if (ack_hold_q) begin
                            st_q <= ST_IDLE;
                        end else begin
                            sh_q <= rd_of(ptr_q, cfg_q, mode_q);
                            sda_oe_n <= rd_of(ptr_q, cfg_q, mode_q) >> 7 == 8'h01;
                            ptr_q <= ptr_q + 8'h01;
                            bit_q <= 4'h1;
                            st_q <= ST_RD;
                        end
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // sda output is a constant low; only the enable moves
    // a registered constant keeps the pad value free of glitches; the high
    // level always comes from the external pullup
    always @(posedge clk or negedge nrst) begin
        if (!nrst)
            sda_out <= 1'b0;
        else
            sda_out <= 1'b0;
    end

    // configuration source and mode selection
    // both outputs follow the same stored bit on the same edge, so the mode
    // never shows a mix of pin and register sources for a cycle
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_from_regs <= 1'b0;
            mode <= 2'h0;
        end else begin
            cfg_from_regs <= cfg_q[`SCS_CFG_SRC_BIT];
            if (cfg_q[`SCS_CFG_SRC_BIT])
                mode <= mode_q[`SCS_MODE_LSB+1:`SCS_MODE_LSB];
            else
                mode <= md_s2_q;
        end
    end

    // filter active only in normal mode with filter on (mode 01)
    // the compatibility modes and normal mode with the filter off pass the
    // control inputs through at the output clock rate
    scs_ctrl_filter u_filt (
        .clk(clk),
        .nrst(nrst),
        .tick(tick),
        .enable(mode == 2'h1),
        .ctrl_in(ci_s2_q),
        .ctrl_out(filt_out)
    );

    // extra register keeps the top output straight from a flip-flop; it
    // costs one clock of latency on the control path
    always @(posedge clk or negedge nrst) begin
        if (!nrst)
            ctrl_out <= 3'h0;
        else
            ctrl_out <= filt_out;
    end
endmodule // scs_slave
`default_nettype wire

// ===== verification/scs_slave_chk.sv
// port checker for the serial control slave
`timescale 1ns/100ps
`default_nettype none
module scs_slave_chk #(
    parameter int PWRUP_CYC = 20
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic [1:0] address_select_pin,
    input wire logic [1:0] mode_pin,
    input wire logic recovered_clock_out,
    input wire logic [2:0] ctrl_in,
    input wire logic [2:0] ctrl_out,
    input wire logic [1:0] mode,
    input wire logic cfg_from_regs,
    input wire logic ready
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    logic [31:0] cyc_q;
    // cycles since release, saturating so it never wraps
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) cyc_q <= 32'h0000_0000;
        else if (cyc_q != 32'hFFFF_FFFF) cyc_q <= cyc_q + 32'h0000_0001;
    end
    a_sda_low_only: assert property (!sda_oe_n |-> sda_out == 1'b0)
        else $error("sda driven high");
    a_early_quiet: assert property (!ready |-> sda_oe_n)
        else $error("bus answered before ready");
    a_ready_due: assert property (cyc_q > PWRUP_CYC + 2 |-> ready)
        else $error("ready late");
    // the slave may only start pulling sda low while scl is low
    a_ack_in_low: assert property ($fell(sda_oe_n) |-> !scl_in)
        else $error("sda pulled during scl high");
    a_cfg_in_low: assert property ($changed(cfg_from_regs) |-> !scl_in)
        else $error("source changed at odd time");
    a_mode_pins: assert property ((!cfg_from_regs && $stable(mode_pin))[*5] |-> mode == mode_pin)
        else $error("mode not from pins");
    a_reset_vals: assert property ($rose(nrst) |-> sda_oe_n && !ready && !cfg_from_regs)
        else $error("bad value after reset");
    a_stop_free: assert property (scl_in && $rose(sda_in) |=> sda_oe_n[*4])
        else $error("sda held after stop");
    c_ack: cover property ($fell(sda_oe_n));
    c_regs: cover property ($rose(cfg_from_regs));
    c_filt: cover property (mode == 2'b01 && ctrl_out == 3'b101);
endmodule // scs_slave_chk
bind scs_slave scs_slave_chk #(.PWRUP_CYC(PWRUP_CYC)) u_chk (
    .clk(clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .address_select_pin(address_select_pin), .mode_pin(mode_pin),
    .recovered_clock_out(recovered_clock_out), .ctrl_in(ctrl_in), .ctrl_out(ctrl_out),
    .mode(mode), .cfg_from_regs(cfg_from_regs), .ready(ready));
`default_nettype wire

// ===== verification/scs_master_model.sv
// bus master model for the serial control pins
`timescale 1ns/100ps
`default_nettype none
module scs_master_model (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_rel
);
    // idle bus: both lines released, scl stands still
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    // half bus period, twice the slave's minimum so slow timing is exercised
    task automatic hp();
        repeat (8) @(negedge clk);
    endtask
    // start or repeated start: sda falls while scl is high
    task automatic start();
        @(negedge clk);
        sda_rel = 1'b1;
        hp();
        scl = 1'b1;
        hp();
        sda_rel = 1'b0;
        hp();
        scl = 1'b0;
    endtask
    // stop: sda rises while scl is high
    task automatic stop();
        @(negedge clk);
        sda_rel = 1'b0;
        hp();
        scl = 1'b1;
        hp();
        sda_rel = 1'b1;
        hp();
    endtask
    // nine slots msb first; a one releases sda, the ninth is the ack slot
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            @(negedge clk);
            sda_rel = tx[i];
            hp();
            scl = 1'b1;
            hp();
            rx[i] = sda;
            scl = 1'b0;
        end
    endtask
endmodule // scs_master_model
`default_nettype wire

// ===== verification/scs_slave_bench.sv
// self-checking bench for the serial control slave
`timescale 1ns/100ps
`default_nettype none
module scs_slave_bench;
    localparam int PWRUP = 400;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic rclk = 1'b0;
    logic [1:0] asel = 2'b11;
    logic [1:0] mpin = 2'b10;
    logic [2:0] cin = 3'b000;
    logic [2:0] seen;
    logic [2:0] seen2;
    logic [8:0] rx;
    logic [6:0] tab [4] = '{7'h71, 7'h72, 7'h73, 7'h76};
    logic [6:0] stab [4] = '{7'h69, 7'h6A, 7'h6B, 7'h6E};
    int err_count = 0;
    int checks = 0;
    wire scl, m_rel, oe_n, so, rdy, cfg;
    wire [2:0] cout;
    wire [1:0] mode;
    wire oe2_n, so2, rdy2, cfg2;
    wire [2:0] cout2;
    wire [1:0] mode2;
    wire sda = oe_n & oe2_n & m_rel; // pulled up unless someone pulls low
    always #20 clk = ~clk;
    always #160 rclk = ~rclk;
    scs_slave #(.IS_DESER(1), .PWRUP_CYC(PWRUP)) uut (
        .clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(so), .sda_oe_n(oe_n),
        .address_select_pin(asel), .mode_pin(mpin), .recovered_clock_out(rclk),
        .ctrl_in(cin), .ctrl_out(cout), .mode(mode), .cfg_from_regs(cfg), .ready(rdy));
    // serializer flavour on the same bus; its address set never overlaps
    scs_slave #(.IS_DESER(0), .PWRUP_CYC(PWRUP)) uut_ser (
        .clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(so2), .sda_oe_n(oe2_n),
        .address_select_pin(asel), .mode_pin(mpin), .recovered_clock_out(rclk),
        .ctrl_in(cin), .ctrl_out(cout2), .mode(mode2), .cfg_from_regs(cfg2), .ready(rdy2));
    scs_master_model mst (.clk(clk), .sda(sda), .scl(scl), .sda_rel(m_rel));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one byte out; the slave's ack shows as a low ninth bit
    task automatic wr(input logic [7:0] b, input logic ack);
        mst.xfer({b, 1'b1}, rx);
        chk("ack", {7'h00, ack}, {7'h00, !rx[0]});
    endtask
    // control pulse n cycles long, then collect what each output let through
    task automatic pulse(input logic [2:0] v, input int n);
        seen = 3'b000;
        seen2 = 3'b000;
        cin = v;
        for (int k = 0; k < n + 40; k++) begin
            if (k == n)
                cin = 3'b000;
            @(negedge clk);
            seen = seen | cout;
            seen2 = seen2 | cout2;
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // watchdog: the tests need about 9000 cycles
    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        final_report();
    end
    initial begin
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        mst.start();
        wr(8'hEC, 1'b0);
        mst.stop();
        chk("cfg", 8'h00, {7'h00, cfg});
        chk("mode", 8'h02, {6'h00, mode});
        for (int i = 0; i < 400 && rdy !== 1'b1; i++) @(negedge clk);
        chk("ready", 8'h01, {7'h00, rdy});
        chk("ser ready", 8'h01, {7'h00, rdy2});
        $display("test reset done");
        for (int s = 0; s < 4; s++) begin
            asel = s[1:0];
            for (int a = 0; a < 4; a++) begin
                mst.start();
                wr({tab[a], 1'b0}, a == s);
                mst.stop();
                mst.start();
                wr({stab[a], 1'b0}, a == s);
                mst.stop();
            end
        end
        $display("test address done");
        mst.start();
        wr(8'hEC, 1'b1);
        wr(8'h00, 1'b1);
        wr(8'h01, 1'b1);
        wr(8'h04, 1'b1);
        mst.stop();
        chk("cfg", 8'h01, {7'h00, cfg});
        chk("mode", 8'h01, {6'h00, mode});
        mst.start();
        wr(8'hEC, 1'b1);
        wr(8'h00, 1'b1);
        mst.start();
        wr(8'hED, 1'b1);
        mst.xfer(9'h1FE, rx);
        chk("rd0", 8'h01, rx[8:1]);
        mst.xfer(9'h1FF, rx);
        chk("rd1", 8'h04, rx[8:1]);
        mst.stop();
        $display("test registers done");
        // pulses one and two output clocks wide must vanish, a held value must pass
        pulse(3'b111, 8);
        chk("glitch", 8'h00, {5'h00, seen});
        chk("ser pass", 8'h07, {5'h00, seen2});
        pulse(3'b111, 16);
        chk("glitch2", 8'h00, {5'h00, seen});
        cin = 3'b101;
        repeat (48) @(negedge clk);
        chk("ctrl", 8'h05, {5'h00, cout});
        mst.start();
        wr(8'hEC, 1'b1);
        wr(8'h00, 1'b1);
        wr(8'h00, 1'b1);
        mst.stop();
        chk("cfg", 8'h00, {7'h00, cfg});
        chk("ser cfg", 8'h00, {7'h00, cfg2});
        for (int m = 0; m < 4; m++) begin
            mpin = m[1:0];
            repeat (8) @(negedge clk);
            chk("mode", m[7:0], {6'h00, mode});
            chk("ser mode", m[7:0], {6'h00, mode2});
        end
        // with the filter off a single output clock pulse passes
        mpin = 2'b00;
        cin = 3'b000;
        repeat (48) @(negedge clk);
        pulse(3'b010, 8);
        chk("pass", 8'h02, {5'h00, seen});
        chk("ser pass", 8'h02, {5'h00, seen2});
        $display("test modes done");
        final_report();
    end
endmodule // scs_slave_bench
`default_nettype wire
